// ===== rtl/sflash_pkg.sv
package sflash_pkg;
	// Opcodes
	localparam logic [7:0] OP_WR_EN = 8'h06;
	localparam logic [7:0] OP_WR_DIS = 8'h04;
	localparam logic [7:0] OP_VOL_EN = 8'h50;
	localparam logic [7:0] OP_RD_ST1 = 8'h05;
	localparam logic [7:0] OP_RD_ST2 = 8'h35;
	localparam logic [7:0] OP_WR_ST = 8'h01;
	localparam logic [7:0] OP_PROG = 8'h02;
	localparam logic [7:0] OP_PROG4 = 8'h32;
	localparam logic [7:0] OP_PROG_SEC = 8'h42;
	localparam logic [7:0] OP_ERASE4K = 8'h20;
	localparam logic [7:0] OP_ERASE32K = 8'h52;
	localparam logic [7:0] OP_ERASE64K = 8'hd8;
	localparam logic [7:0] OP_ERASE_SEC = 8'h44;
	localparam logic [7:0] OP_CHIP_A = 8'hc7;
	localparam logic [7:0] OP_CHIP_B = 8'h60;
	localparam logic [7:0] OP_SUSPEND = 8'h75;
	localparam logic [7:0] OP_RESUME = 8'h7a;
	localparam logic [7:0] OP_PWR_DOWN = 8'hb9;
	localparam logic [7:0] OP_WAKE_ID = 8'hab;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_FAST = 8'h0b;
	localparam logic [7:0] OP_RD_SEC = 8'h48;
	localparam logic [7:0] OP_MAKER_ID = 8'h90;
	localparam logic [7:0] OP_JEDEC = 8'h9f;
	localparam logic [7:0] OP_FL_ON = 8'h38;
	localparam logic [7:0] OP_FL_OFF = 8'hff;
	localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
	localparam logic [7:0] OP_DUAL_IO = 8'hbb;
	localparam logic [7:0] OP_DUAL_ID = 8'h92;
	localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
	localparam logic [7:0] OP_QUAD_IO = 8'heb;
	localparam logic [7:0] OP_QUAD_WORD = 8'he7;
	localparam logic [7:0] OP_QUAD_OCT = 8'he3;
	localparam logic [7:0] OP_QUAD_ID = 8'h94;
	// Status bit positions and writable mask
	localparam int ST_BUSY = 0;
	localparam int ST_WEL = 1;
	localparam int ST_SUS = 15;
	localparam logic [15:0] ST_WR_MASK = 16'h7ffc;
	localparam logic [15:0] ST_RESET = 16'h0000;
	// Identity bytes, values arbitrary
	localparam logic [7:0] MAKER_CODE_BYTE = 8'h5a;
	localparam logic [7:0] PART_CODE_BYTE = 8'h3c;
	localparam logic [15:0] JEDEC_PART = 16'h4321;
	// Framing constants
	localparam logic [5:0] FL_DUMMY_CLK = 6'h02;
	localparam logic [5:0] FL_WAKE_CLK = 6'h06;
	localparam logic [8:0] PAGE_BYTES = 9'h100;
	// Internal cycle times, in microseconds, and core clock rate
	localparam int CORE_MHZ = 20;
	localparam int PROG_TIME_US = 700;
	localparam int ERASE_TIME_US = 45000;
	localparam int SRW_TIME_US = 10000;
	localparam int PROG_CYC_DEF = PROG_TIME_US * CORE_MHZ;
	localparam int ERASE_CYC_DEF = ERASE_TIME_US * CORE_MHZ;
	localparam int SRW_CYC_DEF = SRW_TIME_US * CORE_MHZ;

	typedef enum logic [2:0] {SRC_NONE, SRC_ARRAY, SRC_ST1, SRC_ST2, SRC_ID,
		SRC_MFID, SRC_JEDEC, SRC_IN} src_t;
	typedef enum logic [1:0] {JOB_NONE, JOB_PROG, JOB_ERASE, JOB_SRW} job_t;
	// Phase layout of one instruction
	typedef struct packed {
		logic ok;
		logic [5:0] addr_clk;
		logic [2:0] addr_ln;
		logic mode;
		logic [5:0] dmy_clk;
		logic [2:0] dat_ln;
		src_t src;
	} desc_t;
	// Accepted command report
	typedef struct packed {
		logic [7:0] opcode;
		logic [23:0] addr;
		logic [7:0] continuation_mode_byte;
		logic [8:0] count;
	} cmd_t;

	// Shift io lines into a word, high line first
	function automatic logic [31:0] shin(logic [31:0] v, logic [3:0] io,
		logic [2:0] ln);
		case (ln)
			3'h4: shin = {v[27:0], io};
			3'h2: shin = {v[29:0], io[1:0]};
			default: shin = {v[30:0], io[0]};
		endcase
	endfunction

	// Instruction layout for each opcode and mode
	function automatic desc_t desc_of(logic [7:0] op, logic fl);
		desc_t d;
		logic fl_ok;
		d = '{1'b1, 6'h00, 3'h1, 1'b0, 6'h00, 3'h1, SRC_NONE};
		fl_ok = 1'b1;
		case (op)
			OP_WR_EN, OP_WR_DIS, OP_VOL_EN, OP_CHIP_A, OP_CHIP_B, OP_SUSPEND,
			OP_RESUME, OP_PWR_DOWN: d.ok = 1'b1;
			OP_FL_ON: fl_ok = 1'b0;
			OP_FL_OFF: d.ok = fl;
			OP_RD_ST1: d.src = SRC_ST1;
			OP_RD_ST2: d.src = SRC_ST2;
			OP_JEDEC: d.src = SRC_JEDEC;
			OP_WR_ST: d.src = SRC_IN;
			OP_PROG: d = '{1'b1, 6'h18, 3'h1, 1'b0, 6'h00, 3'h1, SRC_IN};
			OP_ERASE4K, OP_ERASE32K, OP_ERASE64K: d.addr_clk = 6'h18;
			OP_FAST: d = '{1'b1, 6'h18, 3'h1, 1'b0, 6'h08, 3'h1, SRC_ARRAY};
			OP_WAKE_ID: d = '{1'b1, 6'h00, 3'h1, 1'b0, 6'h18, 3'h1, SRC_ID};
			OP_MAKER_ID: d = '{1'b1, 6'h18, 3'h1, 1'b0, 6'h00, 3'h1, SRC_MFID};
			default: begin
				fl_ok = 1'b0;
				case (op)
					OP_READ: d.src = SRC_ARRAY;
					OP_PROG_SEC: d.src = SRC_IN;
					OP_PROG4: d = '{1'b1, 6'h18, 3'h1, 1'b0, 6'h00, 3'h4, SRC_IN};
					OP_RD_SEC: d.dmy_clk = 6'h08;
					OP_DUAL_OUT: d = '{1'b1, 6'h18, 3'h1, 1'b0, 6'h08, 3'h2, SRC_ARRAY};
					OP_QUAD_OUT: d = '{1'b1, 6'h18, 3'h1, 1'b0, 6'h08, 3'h4, SRC_ARRAY};
					OP_DUAL_IO: d = '{1'b1, 6'h10, 3'h2, 1'b1, 6'h00, 3'h2, SRC_ARRAY};
					OP_DUAL_ID: d = '{1'b1, 6'h10, 3'h2, 1'b1, 6'h00, 3'h2, SRC_MFID};
					OP_QUAD_WORD: d = '{1'b1, 6'h08, 3'h4, 1'b1, 6'h02, 3'h4, SRC_ARRAY};
					OP_QUAD_OCT: d = '{1'b1, 6'h08, 3'h4, 1'b1, 6'h00, 3'h4, SRC_ARRAY};
					OP_QUAD_ID: d = '{1'b1, 6'h08, 3'h4, 1'b1, 6'h04, 3'h4, SRC_MFID};
					OP_ERASE_SEC: d.addr_clk = 6'h18;
					default: d.ok = 1'b0;
				endcase
				if (op inside {OP_READ, OP_PROG_SEC, OP_RD_SEC})
					d.addr_clk = 6'h18;
				if (op == OP_RD_SEC)
					d.src = SRC_ARRAY;
			end
		endcase
		if (op == OP_QUAD_IO) begin
			d = '{1'b1, 6'h08, 3'h4, 1'b1, 6'h04, 3'h4, SRC_ARRAY};
			fl_ok = 1'b1;
		end
		if (fl) begin
			d.ok = d.ok & fl_ok;
			d.addr_clk = (d.addr_clk == 6'h00) ? 6'h00 : (d.mode ? 6'h08 : 6'h06);
			d.dmy_clk = (op == OP_WAKE_ID) ? FL_WAKE_CLK :
				((d.dmy_clk == 6'h00) ? 6'h00 : FL_DUMMY_CLK);
			d.addr_ln = 3'h4;
			d.dat_ln = 3'h4;
		end
		return d;
	endfunction
endpackage

// ===== rtl/serial_flash_instruction_front_end.sv
`timescale 1ns/1ns
`default_nettype none
module serial_flash_instruction_front_end
	import sflash_pkg::*;
#(
	parameter int unsigned PROG_CYC = PROG_CYC_DEF,
	parameter int unsigned ERASE_CYC = ERASE_CYC_DEF,
	parameter int unsigned SRW_CYC = SRW_CYC_DEF
) (
	// Core clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// Flash pins
	input wire logic sclk,
	input wire logic sel_n,
	input wire logic [3:0] io_in,
	output logic [3:0] io_out,
	output logic [3:0] io_oen,
	// Array read port, link clock
	output logic [23:0] link_rd_addr,
	input wire logic [7:0] link_rd_byte,
	// Command report, core clock
	output logic cmd_valid,
	output cmd_t cmd,
	output logic busy,
	output logic [15:0] status,
	output logic power_down,
	// Page buffer readback
	input wire logic [7:0] page_idx,
	output logic [7:0] page_byte
);
	// Link side state, rising edge of sclk
	typedef struct packed {
		logic [11:0] clks;
		logic [11:0] bits;
		logic [7:0] op;
		logic [31:0] sh;
		logic [7:0] ish;
		logic [3:0] inb;
		logic [7:0] pidx;
		logic [8:0] pcnt;
		logic [255:0][7:0] page;
		logic [7:0] osh;
		logic [3:0] orem;
		logic odrv;
		logic arr_ld;
		logic [1:0] alt;
		logic [23:0] raddr;
		logic four_line_command_mode;
		logic fl_pend;
		logic [16:0] lvl_s1;
		logic [16:0] lvl_s2;
	} lnk_t;
	// Pin drivers, falling edge of sclk
	typedef struct packed {
		logic [3:0] out;
		logic [3:0] oen;
	} neg_t;
	// Core side state
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic sel_lvl;
		logic [15:0] st;
		logic [15:0] nv_st;
		logic vol_en;
		logic pd;
		logic [23:0] cnt;
		job_t job;
		logic cmd_valid;
		cmd_t cmd;
		logic [7:0] page_byte;
	} core_t;

	lnk_t l_ff, nxt_l;
	neg_t n_ff, nxt_n;
	core_t c_ff, nxt_c;
	logic frame_on_ff;
	desc_t d;
	logic [5:0] opc;
	logic [11:0] c_addr;
	logic [11:0] c_data;
	logic [2:0] ln;
	logic [31:0] nsh;
	logic [7:0] nop;
	src_t osrc;
	logic [7:0] obyte;
	logic [7:0] ibyte;
	logic [7:0] cur;
	logic [11:0] idx;
	desc_t fd;
	logic [5:0] fopc;
	desc_t cd;
	logic rise;
	logic accept;
	logic whole;
	logic adr_done;

	// Frame marker, cleared by select high
	always_ff @(posedge sclk or posedge sel_n) begin
		if (sel_n)
			frame_on_ff <= 1'b0;
		else
			frame_on_ff <= 1'b1;
	end

	// Link side decode of the serial stream
	always_comb begin
		nxt_l = l_ff;
		if (!frame_on_ff) begin
			nxt_l.clks = 12'h000;
			nxt_l.bits = 12'h000;
			nxt_l.op = 8'h00;
			nxt_l.sh = 32'h0;
			nxt_l.inb = 4'h0;
			nxt_l.pidx = 8'h00;
			nxt_l.pcnt = 9'h000;
			nxt_l.orem = 4'h0;
			nxt_l.odrv = 1'b0;
			nxt_l.arr_ld = 1'b0;
			nxt_l.alt = 2'h0;
			nxt_l.four_line_command_mode = l_ff.fl_pend;
		end
		nxt_l.lvl_s1 = {c_ff.pd, c_ff.st};
		nxt_l.lvl_s2 = l_ff.lvl_s1;
		idx = nxt_l.clks;
		opc = nxt_l.four_line_command_mode ? 6'h02 : 6'h08;
		d = desc_of(nxt_l.op, nxt_l.four_line_command_mode);
		c_addr = 12'(opc) + 12'(d.addr_clk);
		c_data = c_addr + 12'(d.dmy_clk);
		// Lines used by this clock
		if (idx < 12'(opc))
			ln = nxt_l.four_line_command_mode ? 3'h4 : 3'h1;
		else if (idx < c_data)
			ln = d.addr_ln;
		else
			ln = d.dat_ln;
		nsh = shin(nxt_l.sh, io_in, ln);
		ibyte = nxt_l.ish;
		nop = nxt_l.op;
		if (idx < 12'(opc)) begin
			nop = 8'(shin({24'h0, nxt_l.op}, io_in, ln));
			nxt_l.op = nop;
		end else if (idx < c_addr) begin
			nxt_l.sh = nsh;
			if (idx == c_addr - 12'h001)
				nxt_l.pidx = nsh[7:0];
		end else if (idx >= c_data && d.src == SRC_IN) begin
			ibyte = 8'(shin({24'h0, nxt_l.ish}, io_in, ln));
			nxt_l.ish = ibyte;
			nxt_l.inb = nxt_l.inb + 4'(ln);
			if (nxt_l.inb == 4'h8) begin
				nxt_l.page[nxt_l.pidx] = ibyte;
				nxt_l.pidx = nxt_l.pidx + 8'h01;
				nxt_l.inb = 4'h0;
				if (nxt_l.pcnt != PAGE_BYTES)
					nxt_l.pcnt = nxt_l.pcnt + 9'h001;
			end
		end
		// Mode switch takes effect at the next frame
		if (idx == 12'(opc) - 12'h001 && !l_ff.lvl_s2[ST_BUSY]) begin
			if (nop == OP_FL_ON && !nxt_l.four_line_command_mode)
				nxt_l.fl_pend = 1'b1;
			if (nop == OP_FL_OFF && nxt_l.four_line_command_mode)
				nxt_l.fl_pend = 1'b0;
		end
		// Output source, gated by busy and power-down
		d = desc_of(nop, nxt_l.four_line_command_mode);
		c_addr = 12'(opc) + 12'(d.addr_clk);
		c_data = c_addr + 12'(d.dmy_clk);
		osrc = d.ok ? d.src : SRC_NONE;
		if (l_ff.lvl_s2[ST_BUSY] && !(nop inside {OP_RD_ST1, OP_RD_ST2}))
			osrc = SRC_NONE;
		if (l_ff.lvl_s2[16] && nop != OP_WAKE_ID)
			osrc = SRC_NONE;
		case (osrc)
			SRC_ST1: obyte = l_ff.lvl_s2[7:0];
			SRC_ST2: obyte = l_ff.lvl_s2[15:8];
			SRC_ID: obyte = PART_CODE_BYTE;
			SRC_MFID: obyte = nxt_l.alt[0] ? PART_CODE_BYTE : MAKER_CODE_BYTE;
			SRC_JEDEC: obyte = (nxt_l.alt == 2'h0) ? MAKER_CODE_BYTE :
				((nxt_l.alt == 2'h1) ? JEDEC_PART[15:8] : JEDEC_PART[7:0]);
			default: obyte = 8'h00;
		endcase
		// Array bytes arrive through the read port
		if (nxt_l.arr_ld) begin
			nxt_l.osh = link_rd_byte << d.dat_ln;
			nxt_l.arr_ld = 1'b0;
		end else begin
			nxt_l.osh = nxt_l.osh << d.dat_ln;
		end
		nxt_l.orem = nxt_l.orem - 4'(d.dat_ln);
		if (osrc inside {SRC_ARRAY, SRC_ST1, SRC_ST2, SRC_ID, SRC_MFID,
			SRC_JEDEC} && idx + 12'h001 >= c_data) begin
			if (idx + 12'h001 == c_data || l_ff.orem == 4'(d.dat_ln)) begin
				nxt_l.orem = 4'h8;
				nxt_l.odrv = 1'b1;
				nxt_l.alt = (nxt_l.alt == 2'h2 && osrc == SRC_JEDEC) ? 2'h0 :
					nxt_l.alt + 2'h1;
				nxt_l.osh = obyte;
				if (osrc == SRC_ARRAY) begin
					nxt_l.arr_ld = 1'b1;
					nxt_l.raddr = (idx + 12'h001 == c_data) ?
						(d.mode ? nxt_l.sh[31:8] : nxt_l.sh[23:0]) :
						l_ff.raddr + 24'h1;
				end
			end
		end
		if (nxt_l.clks != 12'hfff)
			nxt_l.clks = nxt_l.clks + 12'h001;
		if (nxt_l.bits < 12'hff8)
			nxt_l.bits = nxt_l.bits + 12'(ln);
	end

	always_ff @(posedge sclk or negedge resetn) begin
		if (!resetn)
			l_ff <= '0;
		else
			l_ff <= nxt_l;
	end

	// Pin drive on falling edge, released as soon as select rises
	always_comb begin
		nxt_n.out = 4'h0;
		nxt_n.oen = 4'hf;
		cur = l_ff.arr_ld ? link_rd_byte : l_ff.osh;
		fd = desc_of(l_ff.op, l_ff.four_line_command_mode);
		if (l_ff.odrv) begin
			case (fd.dat_ln)
				3'h4: begin
					nxt_n.out = cur[7:4];
					nxt_n.oen = 4'h0;
				end
				3'h2: begin
					nxt_n.out = {2'h0, cur[7:6]};
					nxt_n.oen = 4'hc;
				end
				default: begin
					nxt_n.out = {2'h0, cur[7], 1'b0};
					nxt_n.oen = 4'hd;
				end
			endcase
		end
	end

	always_ff @(negedge sclk or negedge resetn or posedge sel_n) begin
		if (!resetn || sel_n)
			n_ff <= '{4'h0, 4'hf};
		else
			n_ff <= nxt_n;
	end

	// Completion decode on the core clock
	always_comb begin
		nxt_c = c_ff;
		nxt_c.s1 = sel_n;
		nxt_c.s2 = c_ff.s1;
		nxt_c.s3 = c_ff.s2;
		rise = 1'b0;
		if (c_ff.s2 == c_ff.s3) begin
			nxt_c.sel_lvl = c_ff.s2;
			rise = c_ff.s2 && !c_ff.sel_lvl;
		end
		nxt_c.cmd_valid = 1'b0;
		nxt_c.page_byte = l_ff.page[page_idx];
		// Internal cycle countdown
		if (c_ff.st[ST_BUSY]) begin
			if (c_ff.cnt <= 24'h000001) begin
				nxt_c.st[ST_BUSY] = 1'b0;
				nxt_c.st[ST_WEL] = 1'b0;
				nxt_c.job = JOB_NONE;
				nxt_c.cnt = 24'h0;
			end else begin
				nxt_c.cnt = c_ff.cnt - 24'h000001;
			end
		end
		cd = desc_of(l_ff.op, l_ff.four_line_command_mode);
		fopc = l_ff.four_line_command_mode ? 6'h02 : 6'h08;
		whole = l_ff.bits[2:0] == 3'h0;
		adr_done = l_ff.clks >= 12'(fopc) + 12'(cd.addr_clk);
		accept = rise && cd.ok && l_ff.clks >= 12'(fopc) && whole;
		if (c_ff.st[ST_BUSY] && !(l_ff.op inside {OP_SUSPEND}))
			accept = 1'b0;
		if (c_ff.pd && l_ff.op != OP_WAKE_ID)
			accept = 1'b0;
		nxt_c.cmd.opcode = l_ff.op;
		nxt_c.cmd.addr = cd.mode ? l_ff.sh[31:8] : l_ff.sh[23:0];
		nxt_c.cmd.continuation_mode_byte = cd.mode ? l_ff.sh[7:0] : 8'h00;
		nxt_c.cmd.count = l_ff.pcnt;
		if (!accept)
			nxt_c.cmd = c_ff.cmd;
		if (accept) begin
			case (l_ff.op)
				OP_WR_EN: nxt_c.st[ST_WEL] = 1'b1;
				OP_WR_DIS: nxt_c.st[ST_WEL] = 1'b0;
				OP_VOL_EN: nxt_c.vol_en = 1'b1;
				OP_WR_ST: begin
					if (l_ff.pcnt != 9'h000 && (c_ff.st[ST_WEL] || c_ff.vol_en)) begin
						nxt_c.st = (c_ff.st & ~ST_WR_MASK) |
							({l_ff.page[1], l_ff.page[0]} & ST_WR_MASK);
						if (l_ff.pcnt == 9'h001)
							nxt_c.st[15:8] = c_ff.st[15:8];
						nxt_c.vol_en = 1'b0;
						if (!c_ff.vol_en) begin
							nxt_c.nv_st = nxt_c.st;
							nxt_c.st[ST_BUSY] = 1'b1;
							nxt_c.job = JOB_SRW;
							nxt_c.cnt = 24'(SRW_CYC);
							nxt_c.cmd_valid = 1'b1;
						end
					end
				end
				OP_PROG, OP_PROG4, OP_PROG_SEC: begin
					if (c_ff.st[ST_WEL] && adr_done && l_ff.pcnt != 9'h000) begin
						nxt_c.st[ST_BUSY] = 1'b1;
						nxt_c.job = JOB_PROG;
						nxt_c.cnt = 24'(PROG_CYC);
						nxt_c.cmd_valid = 1'b1;
					end
				end
				OP_ERASE4K, OP_ERASE32K, OP_ERASE64K, OP_ERASE_SEC, OP_CHIP_A,
				OP_CHIP_B: begin
					if (c_ff.st[ST_WEL] && adr_done) begin
						nxt_c.st[ST_BUSY] = 1'b1;
						nxt_c.job = JOB_ERASE;
						nxt_c.cnt = 24'(ERASE_CYC);
						nxt_c.cmd_valid = 1'b1;
					end
				end
				OP_SUSPEND: begin
					if (c_ff.st[ST_BUSY] && c_ff.job inside {JOB_PROG, JOB_ERASE}) begin
						nxt_c.st[ST_BUSY] = 1'b0;
						nxt_c.st[ST_SUS] = 1'b1;
						nxt_c.cnt = c_ff.cnt;
					end
				end
				OP_RESUME: begin
					if (c_ff.st[ST_SUS]) begin
						nxt_c.st[ST_SUS] = 1'b0;
						nxt_c.st[ST_BUSY] = 1'b1;
					end
				end
				OP_PWR_DOWN: nxt_c.pd = 1'b1;
				OP_WAKE_ID: nxt_c.pd = 1'b0;
				default: nxt_c.pd = c_ff.pd;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			c_ff <= '{1'b1, 1'b1, 1'b1, 1'b1, ST_RESET, ST_RESET, 1'b0, 1'b0,
				24'h0, JOB_NONE, 1'b0, '0, 8'h00};
		else
			c_ff <= nxt_c;
	end

	// Outputs straight from flops
	assign io_out = n_ff.out;
	assign io_oen = n_ff.oen;
	assign link_rd_addr = l_ff.raddr;
	assign cmd_valid = c_ff.cmd_valid;
	assign cmd = c_ff.cmd;
	assign busy = c_ff.st[ST_BUSY];
	assign status = c_ff.st;
	assign power_down = c_ff.pd;
	assign page_byte = c_ff.page_byte;

	// Checks
	sequence sel_rise_s;
		!c_ff.sel_lvl ##1 c_ff.sel_lvl;
	endsequence
	frame_start_a: assert property (@(posedge sclk) disable iff (!resetn)
		!frame_on_ff && !sel_n |=> l_ff.clks == 12'h001)
		else $error("frame did not start counting");
	nibble_pair_a: assert property (@(posedge sclk) disable iff (!resetn)
		frame_on_ff && l_ff.four_line_command_mode && l_ff.clks == 12'h002
		|-> l_ff.bits == 12'h008) else $error("four-line byte not in two clocks");
	quiet_start_a: assert property (@(posedge sclk) disable iff (!resetn)
		!frame_on_ff |-> io_oen == 4'hf) else $error("pins driven between frames");
	done_event_a: assert property (@(posedge core_clk) disable iff (!resetn)
		cmd_valid |-> c_ff.sel_lvl && !$past(c_ff.sel_lvl))
		else $error("command not tied to select rise");
	byte_bound_a: assert property (@(posedge core_clk) disable iff (!resetn)
		cmd_valid |-> l_ff.bits[2:0] == 3'h0) else $error("partial byte accepted");
	busy_ignore_a: assert property (@(posedge core_clk) disable iff (!resetn)
		sel_rise_s ##0 (busy && l_ff.op == OP_WR_DIS) |=> status[ST_WEL] ||
		!busy) else $error("instruction taken while busy");
	page_cap_a: assert property (@(posedge core_clk) disable iff (!resetn)
		cmd_valid && cmd.opcode == OP_PROG |-> cmd.count inside {[9'h001:9'h100]})
		else $error("page count out of range");
	suspend_a: assert property (@(posedge core_clk) disable iff (!resetn)
		$rose(status[ST_SUS]) |-> $fell(busy) ##1 !busy[*2])
		else $error("suspend left cycle running");
	sleep_a: assert property (@(posedge core_clk) disable iff (!resetn)
		$rose(power_down) |-> $past(l_ff.op) == OP_PWR_DOWN)
		else $error("power-down without its opcode");
endmodule
`default_nettype wire

// ===== verification/flash_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module flash_host_model (
	// Link pins
	output logic sclk,
	output logic sel_n,
	output wire logic [3:0] io_in,
	input wire logic [3:0] io_out,
	input wire logic [3:0] io_oen
);
	logic [3:0] drv;
	logic drove;
	// Wire level, device lines win where enabled
	assign io_in = (io_out & ~io_oen) | (drv & io_oen);
	// Clock stands still between frames
	initial begin
		sclk = 1'b0;
		sel_n = 1'b1;
		drv = 4'h5;
		drove = 1'b0;
	end
	// Notes any line the device drives
	always @(io_oen) begin
		if (io_oen !== 4'hf)
			drove = 1'b1;
	end
	// One clock, set while low, sampled on rise
	task automatic tick(input logic [3:0] v, output logic [3:0] s);
		drv = v;
		#3 sclk = 1'b1;
		s = io_in;
		#3 sclk = 1'b0;
	endtask
	// Select low opens a frame
	task automatic open_frame();
		sel_n = 1'b0;
		#3;
	endtask
	// Select high ends it, released lines toggle
	task automatic close_frame();
		#3 sel_n = 1'b1;
		drv = ~drv;
	endtask
	// Byte MSB first, one line or two nibbles
	task automatic send(input logic [7:0] b, input int ln);
		logic [3:0] s;
		if (ln == 4) begin
			tick(b[7:4], s);
			tick(b[3:0], s);
		end else begin
			for (int i = 7; i >= 0; i--)
				tick({~b[i], ~b[i], ~b[i], b[i]}, s);
		end
	endtask
	// Byte back on one, two or four lines
	task automatic recv(output logic [7:0] b, input int ln);
		logic [3:0] s;
		b = 8'h00;
		for (int i = 0; i < 8 / ln; i++) begin
			tick(~drv, s);
			if (ln == 4)
				b = {b[3:0], s};
			else if (ln == 2)
				b = {b[5:0], s[1:0]};
			else
				b = {b[6:0], s[1]};
		end
	endtask
endmodule
`default_nettype wire

// ===== verification/serial_flash_instruction_front_end_bench.sv
`timescale 1ns/1ns
`default_nettype none
module serial_flash_instruction_front_end_bench;
	import sflash_pkg::*;
	logic core_clk = 1'b0;
	logic resetn;
	logic [7:0] page_idx;
	wire logic sclk;
	wire logic sel_n;
	wire logic [3:0] io_in;
	wire logic [3:0] io_out;
	wire logic [3:0] io_oen;
	wire logic [23:0] link_rd_addr;
	wire logic [7:0] link_rd_byte;
	logic cmd_valid;
	cmd_t cmd;
	cmd_t last;
	logic busy;
	logic [15:0] status;
	logic power_down;
	logic [7:0] page_byte;
	int n_cmd = 0;
	int errors = 0;
	int samples_checked = 0;
	int ln;
	logic [23:0] adr;
	logic [7:0] b;
	logic [7:0] b2;

	// Array answers at once with a known pattern
	assign link_rd_byte = link_rd_addr[7:0] ^ 8'ha5;
	always #25 core_clk = ~core_clk;

	serial_flash_instruction_front_end #(.PROG_CYC(200), .ERASE_CYC(100),
		.SRW_CYC(100)) dut (.core_clk(core_clk), .resetn(resetn),
		.sclk(sclk), .sel_n(sel_n), .io_in(io_in), .io_out(io_out),
		.io_oen(io_oen), .link_rd_addr(link_rd_addr),
		.link_rd_byte(link_rd_byte), .cmd_valid(cmd_valid), .cmd(cmd),
		.busy(busy), .status(status), .power_down(power_down),
		.page_idx(page_idx), .page_byte(page_byte));
	flash_host_model host (.sclk(sclk), .sel_n(sel_n), .io_in(io_in),
		.io_out(io_out), .io_oen(io_oen));

	// Counts started commands
	always @(posedge core_clk) begin
		if (cmd_valid === 1'b1) begin
			n_cmd <= n_cmd + 1;
			last <= cmd;
		end
	end

	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// Opcode, address, data bytes, then stray bits
	task automatic wr(input logic [7:0] op, input int na, input int nd,
		input logic [7:0] d, input int xb);
		logic [3:0] s;
		host.open_frame();
		host.send(op, ln);
		for (int i = na - 1; i >= 0; i--)
			host.send(adr[8*i +: 8], ln);
		for (int i = 0; i < nd; i++)
			host.send(d + 8'(i), ln);
		repeat (xb) host.tick(4'h1, s);
		host.close_frame();
		settle(8);
	endtask
	// Opcode, address, dummies, two bytes back
	task automatic rd(input logic [7:0] op, input int na, input int nd,
		input int lo);
		host.open_frame();
		host.send(op, ln);
		for (int i = na - 1; i >= 0; i--)
			host.send(adr[8*i +: 8], ln);
		repeat (nd) host.send(8'h00, ln);
		host.recv(b, lo);
		host.recv(b2, lo);
		host.close_frame();
		settle(8);
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 400 && busy !== 1'b0; i++)
			@(posedge core_clk);
		check("busy end", 0, busy);
	endtask

	task automatic t_wel();
		rd(OP_RD_ST1, 0, 0, 1);
		check("status reset", 8'h00, b);
		wr(OP_WR_EN, 0, 0, 8'h00, 0);
		rd(OP_RD_ST1, 0, 0, 1);
		check("wel set", 8'h02, b);
		check("wel repeat", 8'h02, b2);
		wr(OP_WR_DIS, 0, 0, 8'h00, 0);
		rd(OP_RD_ST1, 0, 0, 1);
		check("wel clear", 8'h00, b);
	endtask
	task automatic t_program();
		int n0;
		n0 = n_cmd;
		wr(OP_WR_EN, 0, 0, 8'h00, 0);
		wr(OP_PROG, 3, 1, 8'hc0, 3);
		check("partial program", n0, n_cmd);
		wr(OP_PROG, 3, 2, 8'hc0, 0);
		check("program taken", n0 + 1, n_cmd);
		check("program op", OP_PROG, last.opcode);
		check("program addr", adr, last.addr);
		check("program count", 2, last.count);
		host.drove = 1'b0;
		rd(OP_READ, 3, 0, 1);
		check("busy read", 0, host.drove);
		rd(OP_RD_ST1, 0, 0, 1);
		check("busy status", 8'h03, b);
		wr(OP_WR_DIS, 0, 0, 8'h00, 0);
		rd(OP_RD_ST1, 0, 0, 1);
		check("busy ignores", 8'h03, b);
		wait_idle();
		@(posedge core_clk) page_idx <= 8'h35;
		settle(3);
		check("page byte", 8'hc1, page_byte);
		check("status idle", 16'h0000, status);
	endtask
	task automatic t_erase();
		logic [7:0] ops [5] = '{OP_ERASE4K, OP_ERASE32K, OP_ERASE64K,
			OP_CHIP_A, OP_CHIP_B};
		foreach (ops[i]) begin
			wr(OP_WR_EN, 0, 0, 8'h00, 0);
			wr(ops[i], (i < 3) ? 3 : 0, 0, 8'h00, 0);
			check("erase op", ops[i], last.opcode);
			wait_idle();
		end
	endtask
	task automatic t_suspend();
		wr(OP_WR_EN, 0, 0, 8'h00, 0);
		wr(OP_PROG, 3, 1, 8'h77, 0);
		check("prog busy", 1, busy);
		wr(OP_SUSPEND, 0, 0, 8'h00, 0);
		check("suspended", 1, status[ST_SUS]);
		check("suspend halt", 0, busy);
		wr(OP_RESUME, 0, 0, 8'h00, 0);
		check("resumed", 0, status[ST_SUS]);
		check("resume busy", 1, busy);
		wait_idle();
	endtask
	task automatic t_status_write();
		wr(OP_WR_EN, 0, 0, 8'h00, 0);
		wr(OP_WR_ST, 0, 2, 8'h3c, 0);
		wait_idle();
		rd(OP_RD_ST2, 0, 0, 1);
		check("status high", 8'h3d, b);
		check("status repeat", 8'h3d, b2);
		wr(OP_VOL_EN, 0, 0, 8'h00, 0);
		wr(OP_WR_ST, 0, 2, 8'h00, 0);
		wait_idle();
		check("volatile write", 16'h0100, status);
	endtask
	task automatic t_reads();
		logic [7:0] ops [4] = '{OP_READ, OP_FAST, OP_DUAL_OUT, OP_QUAD_OUT};
		int dm [4] = '{0, 1, 1, 1};
		int lo [4] = '{1, 1, 2, 4};
		adr = 24'h000010;
		foreach (ops[i]) begin
			rd(ops[i], 3, dm[i], lo[i]);
			check("read first", 8'hb5, b);
			check("read next", 8'hb4, b2);
		end
		wr(OP_READ, 3, 0, 8'h00, 3);
		check("abort release", 4'hf, io_oen);
	endtask
	task automatic t_power();
		wr(OP_PWR_DOWN, 0, 0, 8'h00, 0);
		check("power down", 1, power_down);
		host.drove = 1'b0;
		rd(OP_RD_ST1, 0, 0, 1);
		check("asleep", 0, host.drove);
		rd(OP_WAKE_ID, 0, 3, 1);
		check("part code", PART_CODE_BYTE, b);
		check("awake", 0, power_down);
	endtask
	task automatic t_quad();
		wr(OP_FL_ON, 0, 0, 8'h00, 0);
		ln = 4;
		rd(OP_RD_ST2, 0, 0, 4);
		check("quad status", 8'h01, b);
		wr(OP_FL_OFF, 0, 0, 8'h00, 0);
		ln = 1;
		rd(OP_RD_ST2, 0, 0, 1);
		check("single again", 8'h01, b);
	endtask

	task automatic report_and_stop();
		$display("checks %0d, errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Main sequence
	initial begin
		resetn = 1'b0;
		page_idx = 8'h00;
		ln = 1;
		adr = 24'h001234;
		settle(10);
		resetn <= 1'b1;
		settle(6);
		t_wel();
		t_program();
		t_erase();
		t_suspend();
		t_status_write();
		t_reads();
		t_power();
		t_quad();
		report_and_stop();
	end
	// Watchdog against a hang
	initial begin
		#3000000;
		errors++;
		report_and_stop();
	end
endmodule
`default_nettype wire
